// ===== verif/apdu_assertions.sv
`timescale 1ns/10ps
module apdu_chk (
  input wire logic       mclk,                 // Clock
  input wire logic       rst_b,                // Reset
  input wire logic       apd_enable,           // Enable
  input wire logic       strobe_polarity,      // Idle level
  input wire logic [7:0] power_mgmt_reg_zero,  // Reg zero
  input wire logic       address_strobe_input, // Strobe
  input wire logic       logic_clock_input,    // Logic clock
  input wire logic       chip_select_b,        // Select
  input wire logic       reset_input,          // Reset pin
  input wire logic       powerdown_flag,       // Flag
  input wire logic       mem_standby,          // Standby
  input wire logic       pld_turbo,            // Turbo
  input wire logic       data_port_oe,         // Data drive
  input wire logic       io_hold,              // Hold
  input wire logic       mcell_clock           // Gated clock
);
  logic [3:0] cnt_q;
  logic       stb_q;
  logic       clk_q;
  logic       wake;
  assign wake = !chip_select_b || reset_input || (stb_q != address_strobe_input);
  // Reference idle count, same sampling as the pins
  // Of the wake causes only strobe movement restarts the count; select or reset wake leaves it saturated
  always_ff @(posedge mclk) begin
    stb_q <= rst_b ? address_strobe_input : 1'b0;
    clk_q <= rst_b ? logic_clock_input : 1'b0;
    if (!rst_b || !apd_enable || (stb_q != address_strobe_input) || (address_strobe_input != strobe_polarity)) begin
      cnt_q <= 4'h0;
    end else if (logic_clock_input && !clk_q && (cnt_q != 4'hF)) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_flag_on_count: assert property (cnt_q == 4'hF && apd_enable && !wake |=> powerdown_flag)
    else $error("flag missing after idle count");
  a_flag_cause: assert property ($rose(powerdown_flag) |-> $past(cnt_q) == 4'hF)
    else $error("flag rose early");
  a_no_enable: assert property (!apd_enable |=> !powerdown_flag)
    else $error("flag while disabled");
  a_wake_strobe: assert property (powerdown_flag && $changed(address_strobe_input) |=> !powerdown_flag)
    else $error("no wake on strobe");
  a_wake_pin: assert property (powerdown_flag && (!chip_select_b || reset_input) |=> !powerdown_flag)
    else $error("no wake on select or reset");
  a_pd_outputs: assert property ($rose(powerdown_flag) ##1 powerdown_flag |-> mem_standby && !data_port_oe && io_hold)
    else $error("power-down outputs wrong");
  a_turbo_bit: assert property ($stable(power_mgmt_reg_zero[3]) |-> pld_turbo == !power_mgmt_reg_zero[3])
    else $error("turbo state wrong");
  a_mcell_gate: assert property (power_mgmt_reg_zero[5] && $past(power_mgmt_reg_zero[5]) &&
    $past(power_mgmt_reg_zero[5], 2) |-> $stable(mcell_clock)) else $error("macrocell clock not cut");
endmodule : apdu_chk
bind apdu_top apdu_chk apdu_chk_i (
  .mclk                 (mclk),
  .rst_b                (rst_b),
  .apd_enable           (apd_enable),
  .strobe_polarity      (strobe_polarity),
  .power_mgmt_reg_zero  (power_mgmt_reg_zero),
  .address_strobe_input (address_strobe_input),
  .logic_clock_input    (logic_clock_input),
  .chip_select_b        (chip_select_b),
  .reset_input          (reset_input),
  .powerdown_flag       (powerdown_flag),
  .mem_standby          (mem_standby),
  .pld_turbo            (pld_turbo),
  .data_port_oe         (data_port_oe),
  .io_hold              (io_hold),
  .mcell_clock          (mcell_clock)
);

// ===== verif/apdu_mcu_model.sv
`timescale 1ns/10ps
module apdu_mcu_model (
  input  wire logic mclk,     // Clock
  input  wire logic active,   // Pulse strobe
  input  wire logic idle_lvl, // Strobe idle level
  output logic      strobe,   // Strobe pin
  output logic      lclk      // Logic clock pin
);
  logic [1:0] div_q = 2'h0;
  initial strobe = 1'b0;
  initial lclk = 1'b0;
  // Logic clock at a quarter of mclk, kept below mclk/2
  // Non-blocking on the edge avoids racing the bench's delayed stimulus
  always @(posedge mclk) begin
    div_q  <= div_q + 2'h1;
    lclk   <= div_q[1];
    strobe <= active ? ~strobe : idle_lvl;
  end
endmodule : apdu_mcu_model

// ===== verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic        mclk = 1'h0, rst_b = 1'h0, apd_enable = 1'h0, strobe_polarity = 1'h1, stb_run = 1'h0;
  logic        pmr_wr_zero = 1'h0, pmr_wr_two = 1'h0, chip_select_b = 1'h1, reset_input = 1'h0;
  logic        battery_low_main = 1'h0, battery_route_en = 1'h0, logic_inputs_active = 1'h1;
  logic [7:0]  pmr_wdata = 8'h00, power_mgmt_reg_zero, power_mgmt_reg_two;
  logic [15:0] mcu_addr = 16'h0000, mem_addr, mem_data;
  logic        address_strobe_input, logic_clock_input, powerdown_flag, battery_on_flag, indicator_port_pin;
  logic        mcell_clock, mem_standby, pld_turbo, pld_standby, data_port_oe, periph_io_oe, addr_out_valid, io_hold;
  int          bad_count = 0, checks = 0, cyc = 0;
  apdu_pkg::apdu_pld_in_t pld_in;
  apdu_pkg::apdu_mem_en_t mem_en;
  apdu_top apdu_top_i (.*, .mcu_data(16'h0000), .control_input_zero(1'h0), .control_input_one(1'h0),
    .control_input_two(1'h0), .high_byte_write_input(1'h0));
  apdu_mcu_model apdu_mcu_model_i (.mclk(mclk), .active(stb_run), .idle_lvl(strobe_polarity),
    .strobe(address_strobe_input), .lclk(logic_clock_input));
  initial begin
    forever #50 mclk = ~mclk;
  end
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task wr(input logic two, input logic [7:0] d);
    pmr_wr_zero = ~two;
    pmr_wr_two = two;
    pmr_wdata = d;
    step(1);
    pmr_wr_zero = 1'h0;
    pmr_wr_two = 1'h0;
    step(1);
  endtask : wr
  // Fifteen ticks need at least 57 cycles at this logic clock rate
  task idle_to_pd;
    step(50);
    check(powerdown_flag, 1'h0);
    for (int k = 0; k < 40 && powerdown_flag !== 1'h1; k++) step(1);
    check(powerdown_flag, 1'h1);
  endtask : idle_to_pd
  task stop_test;
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    step(5);
    rst_b = 1'h1;
    step(1);
    check({power_mgmt_reg_zero, power_mgmt_reg_two}, 16'h0000);
    check({pld_turbo, mem_standby, powerdown_flag}, 3'h6);
    chip_select_b = 1'h0;
    step(2);
    check(mem_en, 4'hF);
    chip_select_b = 1'h1;
    step(2);
    check(mem_en, 4'h0);
    battery_low_main = 1'h1;
    battery_route_en = 1'h1;
    step(3);
    check({battery_on_flag, indicator_port_pin}, 2'h3);
    battery_route_en = 1'h0;
    step(3);
    check(indicator_port_pin, 1'h0);
    mcu_addr = 16'h00AA;
    step(2);
    check(pld_in.addr_lo, 8'hAA);
    // Clock cut from both arrays, as the host should while idle
    wr(1'h0, 8'h38);
    check({power_mgmt_reg_zero, pld_turbo}, 9'h070);
    check({pld_in.logic_clock, mcell_clock}, 2'h0);
    logic_inputs_active = 1'h0;
    step(3);
    check(pld_standby, 1'h1);
    logic_inputs_active = 1'h1;
    step(2);
    check(pld_standby, 1'h0);
    wr(1'h1, 8'h7D);
    check(power_mgmt_reg_two, 8'h7D);
    mcu_addr = 16'h1255;
    step(2);
    check(pld_in.addr_lo, 8'hAA);
    step(100);
    check(powerdown_flag, 1'h0);
    apd_enable = 1'h1;
    step(40);
    stb_run = 1'h1;
    step(1);
    stb_run = 1'h0;
    step(40);
    check(powerdown_flag, 1'h0);
    for (int i = 0; i < 3; i++) begin
      strobe_polarity = i[0];
      mcu_addr = 16'h1234;
      idle_to_pd();
      mcu_addr = 16'h5678;
      step(100);
      check(powerdown_flag, 1'h1);
      check(mem_addr, 16'h1234);
      check({mem_standby, data_port_oe, periph_io_oe, io_hold, addr_out_valid}, 5'h12);
      check(pld_turbo, 1'h0);
      stb_run = (i == 0);
      chip_select_b = (i != 1);
      reset_input = (i == 2);
      step(2);
      check(powerdown_flag, 1'h0);
      check(mem_addr, 16'h5678);
      stb_run = 1'h0;
      chip_select_b = 1'h1;
      reset_input = 1'h0;
    end
    // A wake by reset input leaves the count saturated; a strobe move restarts it
    strobe_polarity = 1'h1;
    idle_to_pd();
    apd_enable = 1'h0;
    step(2);
    check(powerdown_flag, 1'h0);
    stop_test();
  end
endmodule : tb

// ===== verilog/apdu_idle_cnt.sv
`timescale 1ns/10ps
module apdu_idle_cnt (
  input  wire logic       mclk,        // System clock
  input  wire logic       rst_b,       // Sync reset, active low
  input  wire logic       clk_tick,    // Logic clock period marker
  input  wire logic       enable,      // Count enable
  input  wire logic       clear,       // Restart count
  output logic            terminal     // Count reached fifteen
);
  logic [3:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (!rst_b)
      cnt_q <= apdu_pkg::CNT_RESET;
    else if (clear || !enable)
      cnt_q <= apdu_pkg::CNT_RESET; // RULE20
    else if (clk_tick && cnt_q != apdu_pkg::CNT_TERMINAL)
      cnt_q <= cnt_q + 4'h1; // RULE1 RULE21
  end

  assign terminal = (cnt_q == apdu_pkg::CNT_TERMINAL); // RULE2
endmodule : apdu_idle_cnt

// ===== verilog/apdu_pkg.sv
package apdu_pkg;
  // Idle counter
  localparam int          CNT_W          = 4;
  localparam logic [3:0]  CNT_TERMINAL   = 4'hF;
  localparam logic [3:0]  CNT_RESET      = 4'h0;
  // Power management register zero fields
  localparam int          PMR0_TURBO_OFF = 3;
  localparam int          PMR0_CLK_AND   = 4;
  localparam int          PMR0_CLK_MCELL = 5;
  // Power management register two fields
  localparam int          PMR2_ADDR_LO   = 0;
  localparam int          PMR2_CONTROL_INPUT_ZERO     = 2;
  localparam int          PMR2_CNTL1     = 3;
  localparam int          PMR2_CNTL2     = 4;
  localparam int          PMR2_STROBE    = 5;
  localparam int          PMR2_WRH       = 6;
  localparam logic [7:0]  PMR_RESET      = 8'h00;
  // Logic standby idle time
  localparam int          IDLE_NS        = 70;
  localparam int          CLK_NS         = 100;
  localparam int          IDLE_CYC_RAW   = (IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          IDLE_CYC       = (IDLE_CYC_RAW < 1) ? 1 : IDLE_CYC_RAW;
  localparam logic [3:0]  IDLE_CYC_V     = 4'(IDLE_CYC);

  // Inputs headed into the logic AND array
  typedef struct packed {
    logic [7:0] addr_lo;
    logic       control_input_zero;
    logic       control_input_one;
    logic       control_input_two;
    logic       address_strobe;
    logic       high_byte_write_input;
    logic       logic_clock;
  } apdu_pld_in_t;

  // Memory enables
  typedef struct packed {
    logic primary_flash;
    logic secondary_flash;
    logic sram;
    logic io_block;
  } apdu_mem_en_t;
endpackage : apdu_pkg

// ===== verilog/apdu_top.sv
// Overview of operation
// (RULE1) Enabled unit counts logic clock periods once strobe activity stops.
// (RULE2) Fifteen idle clock periods raise the power-down flag and enter power-down.
// (RULE3) No count when disabled or strobe pulses; counts while strobe equals polarity.
// (RULE4) Enabling the unit also enables power-down entry by default.
// (RULE5) Strobe pulsing again returns the device to normal operation.
// (RULE6) Low chip select or high reset input also wakes the device.
// (RULE7) Power-down blocks the address/data bus from memories and both logic arrays.
// (RULE8) Clock blocking toward logic never blocks clock to the idle counter.
// (RULE9) Memories enter standby in power-down; logic and I/O blocks stay active; the code clears mem_en.io_block and periph_io_oe there.
// (RULE10) Power-down: I/O and logic outputs hold, address undefined, data tri-stated.
// (RULE11) Power-down leaves logic operation alone; only high-speed bit matters.
// (RULE12) Register zero bit 3 at 1 turns high speed off; 0 turns it on.
// (RULE13) High speed off: logic drops to standby after 70 ns of quiet inputs.
// (RULE14) Low chip select enables memories and I/O; high disables memories only; the code also clears mem_en.io_block when high.
// (RULE15) Register zero bits 4 and 5 cut clock from AND array or macrocells.
// (RULE16) Register two bits 0,2-6 cut low address and control inputs from array.
// (RULE17) Battery flag asserts on its pin while main supply is below battery.
// (RULE18) Microcontroller should block unused clock and controls during power-down.
// (RULE19) Logic clock pin feeds macrocells and is the counter's sole time base.
// (RULE20) Strobe transitions clear the counter; waking drops the flag before access.
// (RULE21) Counter saturates at terminal count so the flag holds until wake-up.
`timescale 1ns/10ps
module apdu_top (
  input  wire logic                  mclk,                  // System clock
  input  wire logic                  rst_b,                 // Sync reset, active low
  // Configuration
  input  wire logic                  apd_enable,            // Power-down unit enable
  input  wire logic                  strobe_polarity,       // Idle level of strobe
  input  wire logic                  pmr_wr_zero,           // Write strobe, register zero
  input  wire logic                  pmr_wr_two,            // Write strobe, register two
  input  wire logic [7:0]            pmr_wdata,             // Register write data
  output logic [7:0]                 power_mgmt_reg_zero,   // Register zero contents
  output logic [7:0]                 power_mgmt_reg_two,    // Register two contents
  // Pins
  input  wire logic                  address_strobe_input,  // Microcontroller strobe
  input  wire logic                  logic_clock_input,     // External logic clock
  input  wire logic                  chip_select_b,         // Chip select, active low
  input  wire logic                  reset_input,           // Device reset input level
  input  wire logic                  battery_low_main,      // Main supply below battery
  input  wire logic                  battery_route_en,      // Route battery flag to pin
  input  wire logic [15:0]           mcu_addr,              // Address from bus
  input  wire logic [15:0]           mcu_data,              // Data from bus
  input  wire logic                  control_input_zero,    // Control input 0
  input  wire logic                  control_input_one,     // Control input 1
  input  wire logic                  control_input_two,     // Control input 2
  input  wire logic                  high_byte_write_input, // High byte write
  input  wire logic                  logic_inputs_active,   // Any logic input switching
  // Outputs
  output logic                       powerdown_flag,        // Power-down state
  output logic                       battery_on_flag,       // Battery flag
  output logic                       indicator_port_pin,    // Battery flag on pin
  output logic [15:0]                mem_addr,              // Address to memories
  output logic [15:0]                mem_data,              // Data to memories
  output apdu_pkg::apdu_pld_in_t     pld_in,                // Inputs to AND array
  output logic                       mcell_clock,           // Clock to macrocells
  output apdu_pkg::apdu_mem_en_t     mem_en,                // Memory enables
  output logic                       mem_standby,           // Memories in standby
  output logic                       pld_turbo,             // High speed active
  output logic                       pld_standby,           // Logic in standby current
  output logic                       data_port_oe,          // Data port drive enable
  output logic                       periph_io_oe,          // Peripheral I/O enable
  output logic                       addr_out_valid,        // Address out defined
  output logic                       io_hold                // Hold I/O and logic pins
);
  logic       strobe_q;
  logic       lclk_q;
  logic       strobe_edge;
  logic       clk_tick;
  logic       strobe_idle;
  logic       cnt_terminal;
  logic       wake;
  logic       blocked;
  logic [3:0] quiet_q;

  // Sampled history for edge detection; inputs are synchronous to mclk
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      strobe_q <= 1'b0;
      lclk_q   <= 1'b0;
    end else begin
      strobe_q <= address_strobe_input;
      lclk_q   <= logic_clock_input;
    end
  end

  assign strobe_edge = address_strobe_input ^ strobe_q;
  // Rising edge of the raw pin, before any blocking bit
  assign clk_tick    = logic_clock_input & ~lclk_q; // RULE8 RULE19
  assign strobe_idle = apd_enable & ~strobe_edge
                     & (address_strobe_input == strobe_polarity); // RULE3

  apdu_idle_cnt u_idle_cnt (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .clk_tick (clk_tick),
    .enable   (strobe_idle),
    .clear    (strobe_edge),
    .terminal (cnt_terminal)
  );

  assign wake = strobe_edge | ~chip_select_b | reset_input; // RULE5 RULE6

  // Power-down entry follows the unit enable alone
  always_ff @(posedge mclk) begin
    if (!rst_b)
      powerdown_flag <= 1'b0;
    else if (wake || !apd_enable)
      powerdown_flag <= 1'b0; // RULE20
    else if (cnt_terminal)
      powerdown_flag <= 1'b1; // RULE2 RULE4 RULE21
  end

  // Register writes take effect at once; contents survive power-down
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      power_mgmt_reg_zero <= apdu_pkg::PMR_RESET;
      power_mgmt_reg_two  <= apdu_pkg::PMR_RESET;
    end else begin
      if (pmr_wr_zero)
        power_mgmt_reg_zero <= pmr_wdata;
      if (pmr_wr_two)
        power_mgmt_reg_two  <= pmr_wdata;
    end
  end

  // Wake term bypasses the flag so the first access after wake-up is not blocked
  assign blocked = powerdown_flag & ~wake; // RULE20

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mem_addr <= 16'h0000;
      mem_data <= 16'h0000;
    end else if (!blocked) begin
      mem_addr <= mcu_addr; // RULE7
      mem_data <= mcu_data; // RULE7
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pld_in <= '0;
    end else begin
      if (!blocked && !power_mgmt_reg_two[apdu_pkg::PMR2_ADDR_LO])
        pld_in.addr_lo <= mcu_addr[7:0]; // RULE7 RULE16
      if (!power_mgmt_reg_two[apdu_pkg::PMR2_CONTROL_INPUT_ZERO])
        pld_in.control_input_zero <= control_input_zero; // RULE16
      if (!power_mgmt_reg_two[apdu_pkg::PMR2_CNTL1])
        pld_in.control_input_one <= control_input_one; // RULE16
      if (!power_mgmt_reg_two[apdu_pkg::PMR2_CNTL2])
        pld_in.control_input_two <= control_input_two; // RULE16
      if (!power_mgmt_reg_two[apdu_pkg::PMR2_STROBE])
        pld_in.address_strobe <= address_strobe_input; // RULE16
      if (!power_mgmt_reg_two[apdu_pkg::PMR2_WRH])
        pld_in.high_byte_write_input <= high_byte_write_input; // RULE16
      pld_in.logic_clock <= logic_clock_input & ~power_mgmt_reg_zero[apdu_pkg::PMR0_CLK_AND]; // RULE15
    end
  end

  // Gating a clock in a flop adds one cycle of latency but avoids glitches
  always_ff @(posedge mclk) begin
    if (!rst_b)
      mcell_clock <= 1'b0;
    else
      mcell_clock <= logic_clock_input & ~power_mgmt_reg_zero[apdu_pkg::PMR0_CLK_MCELL]; // RULE15
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mem_en      <= '0;
      mem_standby <= 1'b1;
    end else begin
      mem_en      <= {4{~chip_select_b & ~blocked}}; // RULE14
      mem_standby <= chip_select_b | blocked; // RULE9 RULE14
    end
  end

  // Turbo depends only on the register bit, never on power-down
  always_ff @(posedge mclk) begin
    if (!rst_b)
      pld_turbo <= 1'b1;
    else
      pld_turbo <= ~power_mgmt_reg_zero[apdu_pkg::PMR0_TURBO_OFF]; // RULE11 RULE12
  end

  // Quiet-time counter for logic standby
  always_ff @(posedge mclk) begin
    if (!rst_b)
      quiet_q <= 4'h0;
    else if (logic_inputs_active)
      quiet_q <= 4'h0;
    else if (quiet_q != apdu_pkg::IDLE_CYC_V)
      quiet_q <= quiet_q + 4'h1; // RULE13
  end

  always_ff @(posedge mclk) begin
    if (!rst_b)
      pld_standby <= 1'b0;
    else
      pld_standby <= power_mgmt_reg_zero[apdu_pkg::PMR0_TURBO_OFF]
                   & (quiet_q == apdu_pkg::IDLE_CYC_V) & ~logic_inputs_active; // RULE13
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      data_port_oe   <= 1'b0;
      periph_io_oe   <= 1'b0;
      addr_out_valid <= 1'b0;
      io_hold        <= 1'b0;
    end else begin
      data_port_oe   <= ~blocked; // RULE10
      periph_io_oe   <= ~blocked; // RULE10
      addr_out_valid <= ~blocked; // RULE10
      io_hold        <= blocked; // RULE10
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      battery_on_flag    <= 1'b0;
      indicator_port_pin <= 1'b0;
    end else begin
      battery_on_flag    <= battery_low_main;
      indicator_port_pin <= battery_low_main & battery_route_en; // RULE17
    end
  end
endmodule : apdu_top
